// ==== pkg/ach_consts.vh ====
// Constants for the administration command handler
`ifndef ACH_CONSTS_VH
`define ACH_CONSTS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define ACH_OP_SET_USER 8'h70
`define ACH_OP_VER_USER 8'h71
`define ACH_OP_GET_KEY 8'h72
`define ACH_OP_VER_SYS 8'h73
`define ACH_OP_PWR_OFF 8'h82
`define ACH_OP_PWR_RESTART 8'h83
// ----------------------------------------
// Replies, sizes and timing
// ----------------------------------------
`define ACH_ACK 8'hfa
`define ACH_NAK 8'hfe
`define ACH_ST_MATCH 8'h00
`define ACH_ST_MISMATCH 8'h01
`define ACH_KEY_BYTES 7
`define ACH_DELAY_BYTES 2'h3
`define ACH_SYS_VALID_HOURS 24
`define ACH_SEC_PER_HOUR 3600
`define ACH_CLK_HZ 50000000
`endif

// ==== hdl/ach_cipher.v ====
// Byte-wise password scrambler and system password derivation
`timescale 1ns/100ps
module ach_cipher #(
  parameter MAXLEN = 16
) (
  // Inputs
  input wire [7:0] data_in,
  input wire [7:0] index,
  input wire [55:0] key,
  input wire [31:0] serial,
  // Outputs
  output wire [7:0] enc_out,
  output wire [7:0] sys_out
);
  wire [2:0] kidx;
  wire [7:0] kbyte;
  wire [7:0] sbyte;
  // Simple reversible mix; not a strong cipher, only hides stored bytes
  assign enc_out = {data_in[4:0], data_in[7:5]} ^ (index ^ 8'h5a);
  assign kidx = (index[2:0] == 3'h7) ? 3'h0 : index[2:0];
  assign kbyte = key[{kidx, 3'h0} +: 8];
  assign sbyte = serial[{index[1:0], 3'h0} +: 8];
  assign sys_out = kbyte ^ sbyte ^ index;
endmodule // ach_cipher

// ==== hdl/ach_top.v ====
// Administration command handler: passwords, key, power control
`timescale 1ns/100ps
`include "ach_consts.vh"
module ach_top #(
  parameter MAXLEN = 16,
  parameter CLK_HZ = `ACH_CLK_HZ
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Command bytes in
  input wire cmd_valid,
  input wire [7:0] cmd_data,
  output wire cmd_ready,
  // Reply bytes out
  output reg rsp_valid,
  output reg [7:0] rsp_data,
  input wire rsp_ready,
  // Clock value and identity
  input wire [55:0] rtc_value,
  input wire [31:0] rtc_seconds,
  input wire [31:0] unit_serial,
  // Policy
  input wire pw_required,
  input wire pw_supplied,
  // Nonvolatile store write port
  output reg nv_we,
  output reg [7:0] nv_addr,
  output reg [7:0] nv_wdata,
  // Power control and status
  output reg power_on,
  output reg power_on_req,
  output reg sys_pw_valid,
  output reg busy
);
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam [31:0] SEC_CYCLES = CLK_HZ;
  localparam [31:0] VALID_SECS = `ACH_SYS_VALID_HOURS * `ACH_SEC_PER_HOUR;
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] S_OP = 4'h0;
  localparam [3:0] S_LEN = 4'h1;
  localparam [3:0] S_PW = 4'h2;
  localparam [3:0] S_DELAY = 4'h3;
  localparam [3:0] S_ACT = 4'h4;
  localparam [3:0] S_ACK = 4'h5;
  localparam [3:0] S_STAT = 4'h6;
  localparam [3:0] S_KEY = 4'h7;
  localparam [3:0] S_NVW = 4'h8;
  reg [3:0] state;
  reg [7:0] opcode;
  reg [7:0] len;
  reg [7:0] cnt;
  reg [7:0] pw_buf [0:MAXLEN-1];
  reg [7:0] stored [0:MAXLEN-1];
  reg [7:0] stored_len;
  reg [55:0] key;
  reg [31:0] valid_since;
  reg [23:0] delay;
  reg [31:0] div;
  reg sec_tick;
  reg mismatch;
  reg refused;
  reg wake_armed;
  reg [7:0] status;
  wire [7:0] enc_byte;
  wire [7:0] sys_byte;
  wire [7:0] cur_byte;
  wire take;
  wire fits;
  integer i;
  // No new command while a reply byte is still waiting for the host
  assign cmd_ready = !rsp_valid && ((state == S_OP) || (state == S_LEN) ||
    (state == S_PW) || (state == S_DELAY));
  assign take = cmd_valid && cmd_ready;
  assign fits = (cnt < MAXLEN);
  assign cur_byte = fits ? pw_buf[cnt[3:0]] : 8'h00;
  ach_cipher #(.MAXLEN(MAXLEN)) u_cipher (
    .data_in(cur_byte),
    .index(cnt),
    .key(key),
    .serial(unit_serial),
    .enc_out(enc_byte),
    .sys_out(sys_byte)
  );
  // ----------------------------------------
  // Second divider
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div <= 32'h0;
      sec_tick <= 1'b0;
    end else if (div >= SEC_CYCLES - 32'h1) begin
      div <= 32'h0;
      sec_tick <= 1'b1;
    end else begin
      div <= div + 32'h1;
      sec_tick <= 1'b0;
    end
  end
  // ----------------------------------------
  // Command engine
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_OP;
      opcode <= 8'h00;
      len <= 8'h00;
      cnt <= 8'h00;
      stored_len <= 8'h00;
      key <= 56'h0;
      valid_since <= 32'h0;
      delay <= 24'h0;
      mismatch <= 1'b0;
      refused <= 1'b0;
      wake_armed <= 1'b0;
      status <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      nv_we <= 1'b0;
      nv_addr <= 8'h00;
      nv_wdata <= 8'h00;
      power_on <= 1'b1;
      power_on_req <= 1'b0;
      sys_pw_valid <= 1'b0;
      busy <= 1'b0;
      for (i = 0; i < MAXLEN; i = i + 1) begin
        pw_buf[i] <= 8'h00;
        stored[i] <= 8'h00;
      end
    end else begin
      nv_we <= 1'b0;
      power_on_req <= 1'b0;
      busy <= (state != S_OP);
      // Only a restart arms the countdown, so power-off alone never wakes
      if (!power_on && wake_armed && sec_tick) begin
        if (delay == 24'h0) begin
          power_on <= 1'b1;
          power_on_req <= 1'b1;
          wake_armed <= 1'b0;
        end else begin
          delay <= delay - 24'h1;
        end
      end
      // Expiry uses wrap-safe difference of seconds
      if (sys_pw_valid && (rtc_seconds - valid_since >= VALID_SECS)) begin
        sys_pw_valid <= 1'b0;
      end
      if (rsp_valid && rsp_ready) begin
        rsp_valid <= 1'b0;
      end
      case (state)
        S_OP: begin
          if (take) begin
            opcode <= cmd_data;
            cnt <= 8'h00;
            mismatch <= 1'b0;
            refused <= 1'b0;
            case (cmd_data)
              `ACH_OP_SET_USER, `ACH_OP_VER_USER, `ACH_OP_VER_SYS: begin
                state <= S_LEN;
              end
              `ACH_OP_GET_KEY: begin
                key <= rtc_value;
                state <= S_ACK;
              end
              `ACH_OP_PWR_OFF: begin
                power_on <= 1'b0;
                wake_armed <= 1'b0;
                delay <= 24'h0;
              end
              `ACH_OP_PWR_RESTART: begin
                wake_armed <= 1'b0;
                state <= S_DELAY;
              end
              default: begin
                state <= S_OP;
              end
            endcase
          end
        end
        S_LEN: begin
          if (take) begin
            len <= cmd_data;
            state <= (cmd_data == 8'h00) ? S_ACT : S_PW;
          end
        end
        S_PW: begin
          if (take) begin
            // Bytes beyond storage depth are taken but dropped
            if (fits) begin
              pw_buf[cnt[3:0]] <= cmd_data;
            end
            if (cnt == len - 8'h1) begin
              cnt <= 8'h00;
              state <= S_ACT;
            end else begin
              cnt <= cnt + 8'h1;
            end
          end
        end
        S_DELAY: begin
          if (take) begin
            delay <= {delay[15:0], cmd_data};
            if (cnt[1:0] == `ACH_DELAY_BYTES - 2'h1) begin
              // Restart: power off now, wake after the delay
              power_on <= 1'b0;
              wake_armed <= 1'b1;
              state <= S_OP;
            end else begin
              cnt <= cnt + 8'h1;
            end
          end
        end
        S_ACT: begin
          // One byte per cycle through the cipher
          if (cnt < len && fits) begin
            if (opcode == `ACH_OP_VER_USER) begin
              if (enc_byte != stored[cnt[3:0]]) begin
                mismatch <= 1'b1;
              end
            end else if (opcode == `ACH_OP_VER_SYS) begin
              if (sys_byte != pw_buf[cnt[3:0]]) begin
                mismatch <= 1'b1;
              end
            end else begin
              pw_buf[cnt[3:0]] <= enc_byte;
            end
            cnt <= cnt + 8'h1;
          end else begin
            cnt <= 8'h00;
            if (opcode == `ACH_OP_VER_USER) begin
              if (len != stored_len) begin
                mismatch <= 1'b1;
              end
              state <= S_ACK;
            end else if (opcode == `ACH_OP_VER_SYS) begin
              if (len == 8'h00) begin
                mismatch <= 1'b1;
              end
              state <= S_ACK;
            end else if (pw_required && !pw_supplied) begin
              refused <= 1'b1;
              state <= S_ACK;
            end else begin
              stored_len <= len;
              state <= S_NVW;
            end
          end
        end
        S_NVW: begin
          if (cnt < len && fits) begin
            stored[cnt[3:0]] <= pw_buf[cnt[3:0]];
            nv_we <= 1'b1;
            nv_addr <= cnt;
            nv_wdata <= pw_buf[cnt[3:0]];
            cnt <= cnt + 8'h1;
          end else begin
            cnt <= 8'h00;
            state <= S_ACK;
          end
        end
        S_ACK: begin
          if (!rsp_valid || rsp_ready) begin
            rsp_valid <= 1'b1;
            rsp_data <= refused ? `ACH_NAK : `ACH_ACK;
            if (opcode == `ACH_OP_VER_USER || opcode == `ACH_OP_VER_SYS) begin
              status <= mismatch ? `ACH_ST_MISMATCH : `ACH_ST_MATCH;
              state <= S_STAT;
            end else if (opcode == `ACH_OP_GET_KEY) begin
              state <= S_KEY;
            end else begin
              state <= S_OP;
            end
            if (opcode == `ACH_OP_VER_SYS && !mismatch) begin
              sys_pw_valid <= 1'b1;
              valid_since <= rtc_seconds;
            end
          end
        end
        S_STAT: begin
          if (rsp_ready) begin
            rsp_valid <= 1'b1;
            rsp_data <= status;
            state <= S_OP;
          end
        end
        S_KEY: begin
          if (rsp_ready) begin
            rsp_valid <= 1'b1;
            rsp_data <= key[{cnt[2:0], 3'h0} +: 8];
            if (cnt == `ACH_KEY_BYTES - 1) begin
              cnt <= 8'h00;
              state <= S_OP;
            end else begin
              cnt <= cnt + 8'h1;
            end
          end
        end
        default: begin
          state <= S_OP;
        end
      endcase
    end
  end
endmodule // ach_top

// ==== sim/ach_top_properties.sv ====
// Port checks for the command handler
`timescale 1ns/100ps
module ach_top_properties #(
  parameter MAXLEN = 16,
  parameter CLK_HZ = 10
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Handshakes
  input wire cmd_ready,
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  input wire rsp_ready,
  // Watched state
  input wire [31:0] rtc_seconds,
  input wire nv_we,
  input wire power_on,
  input wire power_on_req,
  input wire sys_pw_valid,
  input wire busy
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // Frozen while valid, so it holds the start second
  reg [31:0] lat;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      lat <= 32'h0;
    else if (!sys_pw_valid)
      lat <= rtc_seconds;
  end
  req_pulse_a: assert property (power_on_req |=> !power_on_req)
    else $error("wake request wider than one cycle");
  req_wake_a: assert property (power_on_req |-> power_on &&
    !$past(power_on)) else $error("wake request without power-on");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data)) else $error("reply dropped");
  reply_block_a: assert property (rsp_valid |-> !cmd_ready)
    else $error("command taken during reply");
  off_quiet_a: assert property ($fell(power_on) |->
    !rsp_valid [*4]) else $error("reply after power-off");
  nv_busy_a: assert property (nv_we |-> busy)
    else $error("store write outside a command");
  valid_cause_a: assert property ($rose(sys_pw_valid) |-> busy)
    else $error("validity set outside a command");
  valid_exp_a: assert property (sys_pw_valid &&
    (rtc_seconds - lat) >= 32'd86400 |-> ##[1:2] !sys_pw_valid)
    else $error("validity outlived its day");
  valid_keep_a: assert property (sys_pw_valid &&
    (rtc_seconds - lat) < 32'd86400 |=> sys_pw_valid)
    else $error("validity cleared early");
endmodule // ach_top_properties

// ==== sim/ach_host.sv ====
// Host model sending framed commands and taking replies
`timescale 1ns/100ps
`include "ach_consts.vh"
module ach_host (
  // Clock
  input wire clk_sys,
  // Command bytes
  input wire cmd_ready,
  output reg cmd_valid,
  output reg [7:0] cmd_data,
  // Reply bytes
  input wire rsp_valid,
  input wire [7:0] rsp_data,
  output reg rsp_ready
);
  integer stall = 0;
  reg hung = 1'b0;
  reg [7:0] pw [0:15];
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    rsp_ready = 1'b0;
  end
  // Idle edge between bytes; released data shows its inverse
  task put(input [7:0] b);
    integer n;
    begin
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_data <= b;
      n = 0;
      @(posedge clk_sys);
      while (!cmd_ready && n < 900) begin
        n = n + 1;
        @(posedge clk_sys);
      end
      hung = hung | (n >= 900);
      cmd_valid <= 1'b0;
      cmd_data <= ~b;
    end
  endtask
  task frame(input [7:0] op, input [7:0] len);
    integer i;
    begin
      put(op);
      put(len);
      for (i = 0; i < len; i = i + 1)
        put(pw[i]);
    end
  endtask
  task restart(input [23:0] d);
    begin
      put(`ACH_OP_PWR_RESTART);
      put(d[23:16]);
      put(d[15:8]);
      put(d[7:0]);
    end
  endtask
  task get(output [7:0] b);
    integer n;
    begin
      repeat (stall + 1) @(posedge clk_sys);
      rsp_ready <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (!rsp_valid && n < 900) begin
        n = n + 1;
        @(posedge clk_sys);
      end
      hung = hung | (n >= 900);
      b = rsp_data;
      rsp_ready <= 1'b0;
    end
  endtask
endmodule // ach_host

// ==== sim/ach_top_tb.sv ====
// Self-checking bench for the command handler
`timescale 1ns/100ps
`include "ach_consts.vh"
module ach_top_tb;
  reg clk_sys;
  reg arst_n;
  wire cmd_valid;
  wire [7:0] cmd_data;
  wire cmd_ready;
  wire rsp_valid;
  wire [7:0] rsp_data;
  wire rsp_ready;
  reg [55:0] rtc_value;
  reg [31:0] rtc_seconds;
  reg [31:0] unit_serial;
  reg pw_required;
  reg pw_supplied;
  wire nv_we;
  wire power_on;
  wire power_on_req;
  wire sys_pw_valid;
  wire [7:0] nv_addr;
  wire [7:0] nv_wdata;
  wire busy;
  reg [7:0] p;
  integer bad_count = 0;
  integer n_tests = 0;
  integer nv_cnt = 0;
  integer i;
  reg [7:0] b;
  reg [55:0] key;
  reg [23:0] rows [0:3];
  ach_top #(.CLK_HZ(10)) dut_u (
    .clk_sys, .arst_n, .cmd_valid, .cmd_data, .cmd_ready,
    .rsp_valid, .rsp_data, .rsp_ready, .rtc_value, .rtc_seconds,
    .unit_serial, .pw_required, .pw_supplied, .nv_we, .nv_addr,
    .nv_wdata, .power_on, .power_on_req, .sys_pw_valid, .busy
  );
  ach_host host_u (
    .clk_sys, .cmd_ready, .cmd_valid, .cmd_data,
    .rsp_valid, .rsp_data, .rsp_ready
  );
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Each stored byte is the scrambled host byte at its own index
  always @(posedge clk_sys) begin
    if (nv_we === 1'b1) begin
      p = host_u.pw[nv_cnt];
      n_tests = n_tests + 1;
      if (nv_addr !== nv_cnt[7:0] ||
        nv_wdata !== ({p[4:0], p[7:5]} ^ nv_cnt[7:0] ^ 8'h5a)) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t bad store %h at %h", $time, nv_wdata, nv_addr);
      end
      nv_cnt = nv_cnt + 1;
    end
  end
  always @(posedge host_u.hung) begin
    bad_count = bad_count + 1;
    $display("[ERR] %0t handshake timeout", $time);
    summarize;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Own index, so callers may loop on i
  task fill(input [7:0] s);
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1)
        host_u.pw[k] = s ^ k[7:0];
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    arst_n = 1'b0;
    rtc_value = 56'h17263544536271;
    rtc_seconds = 32'h100;
    unit_serial = 32'hc3a55a3c;
    pw_required = 1'b1;
    pw_supplied = 1'b0;
    // Length, seed, status
    rows[0] = 24'h043100;
    rows[1] = 24'h043201;
    rows[2] = 24'h033101;
    rows[3] = 24'h003101;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk({7'h0, power_on}, 8'h01);
    chk({7'h0, sys_pw_valid}, 8'h00);
    chk({7'h0, busy}, 8'h00);
    $display("end reset");
    fill(8'h31);
    host_u.frame(`ACH_OP_SET_USER, 8'h04);
    host_u.get(b);
    chk(b, `ACH_NAK);
    chk(nv_cnt[7:0], 8'h00);
    pw_supplied <= 1'b1;
    host_u.frame(`ACH_OP_SET_USER, 8'h04);
    host_u.get(b);
    chk(b, `ACH_ACK);
    chk(nv_cnt[7:0], 8'h04);
    $display("end set");
    for (i = 0; i < 4; i = i + 1) begin
      host_u.stall = i;
      fill(rows[i][15:8]);
      host_u.frame(`ACH_OP_VER_USER, rows[i][23:16]);
      host_u.get(b);
      chk(b, `ACH_ACK);
      host_u.get(b);
      chk(b, rows[i][7:0]);
    end
    $display("end verify table");
    key = rtc_value;
    host_u.put(`ACH_OP_GET_KEY);
    host_u.get(b);
    chk(b, `ACH_ACK);
    for (i = 0; i < 7; i = i + 1) begin
      host_u.get(b);
      chk(b, key[8*i +: 8]);
      host_u.pw[i] = key[8*i +: 8] ^ unit_serial[8*(i%4) +: 8] ^ i[7:0];
    end
    // Clock moves on; the retained key must be used
    rtc_value <= 56'h0;
    host_u.pw[6] = ~host_u.pw[6];
    host_u.frame(`ACH_OP_VER_SYS, 8'h07);
    host_u.get(b);
    chk(b, `ACH_ACK);
    host_u.get(b);
    chk(b, `ACH_ST_MISMATCH);
    chk({7'h0, sys_pw_valid}, 8'h00);
    host_u.pw[6] = ~host_u.pw[6];
    host_u.frame(`ACH_OP_VER_SYS, 8'h07);
    host_u.get(b);
    chk(b, `ACH_ACK);
    host_u.get(b);
    chk(b, `ACH_ST_MATCH);
    chk({7'h0, sys_pw_valid}, 8'h01);
    rtc_seconds <= 32'h100 + 32'd86399;
    repeat (4) @(posedge clk_sys);
    chk({7'h0, sys_pw_valid}, 8'h01);
    rtc_seconds <= 32'h100 + 32'd86400;
    repeat (4) @(posedge clk_sys);
    chk({7'h0, sys_pw_valid}, 8'h00);
    $display("end system password");
    // 258 s at ten cycles a second
    host_u.restart(24'h000102);
    repeat (2544) @(posedge clk_sys);
    chk({7'h0, power_on}, 8'h00);
    i = 0;
    while (power_on_req !== 1'b1 && i < 100) begin
      i = i + 1;
      @(posedge clk_sys);
    end
    chk({7'h0, power_on_req}, 8'h01);
    @(posedge clk_sys);
    chk({7'h0, power_on}, 8'h01);
    $display("end restart");
    host_u.put(`ACH_OP_PWR_OFF);
    repeat (3) @(posedge clk_sys);
    chk({7'h0, power_on}, 8'h00);
    chk({7'h0, rsp_valid}, 8'h00);
    // Nothing armed a wake, so power stays off over several seconds
    repeat (40) @(posedge clk_sys);
    chk({7'h0, power_on}, 8'h00);
    $display("end power off");
    // Reset in mid-run brings power back and a working engine
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk({7'h0, power_on}, 8'h01);
    chk({7'h0, busy}, 8'h00);
    key = 56'h0a1b2c3d4e5f60;
    rtc_value <= key;
    host_u.put(`ACH_OP_GET_KEY);
    host_u.get(b);
    chk(b, `ACH_ACK);
    for (i = 0; i < 7; i = i + 1) begin
      host_u.get(b);
      chk(b, key[8*i +: 8]);
    end
    $display("end mid-run reset");
    summarize;
  end
endmodule // ach_top_tb
bind ach_top ach_top_properties #(.MAXLEN(MAXLEN), .CLK_HZ(CLK_HZ)) prop_u (
  .clk_sys, .arst_n, .cmd_ready, .rsp_valid, .rsp_data, .rsp_ready,
  .rtc_seconds, .nv_we, .power_on, .power_on_req, .sys_pw_valid, .busy
);
